// [sfl_defs.vh]
`ifndef SFL_DEFS_VH
`define SFL_DEFS_VH

// Control bytes exchanged with the host.
`define SFL_B_MATCH_END 8'h00
`define SFL_B_SYNC 8'h55
`define SFL_B_SYNC_ACK 8'hAA
`define SFL_B_ERASE_FAIL 8'hFF
`define SFL_B_XON 8'h11
`define SFL_B_ACK 8'h06
`define SFL_B_BEL 8'h07
`define SFL_B_WCMD 8'h57
`define SFL_B_REC_S 8'h53
`define SFL_B_REC_9 8'h39
`define SFL_B_REC_8 8'h38

// Image chunk length in bytes, as last index.
`define SFL_CHUNK_LAST 7'h3F

// Header lengths in bytes, as last index.
`define SFL_HDR_ERASE_LAST 3'h3
`define SFL_HDR_IMAGE_LAST 3'h5

// Flash block size in bytes.
`define SFL_BLK_BYTES 24'h001000

// Flash engine command codes.
`define SFL_FC_ERASE_ALL 2'h0
`define SFL_FC_BLANK 2'h1
`define SFL_FC_ERASE_BLK 2'h2
`define SFL_FC_PROG 2'h3

// Loader RAM and receive FIFO geometry.
`define SFL_RAM_AW 10
`define SFL_FIFO_W 8
`define SFL_FIFO_D 32
`define SFL_FIFO_AW 5

// Cycles the mode strap is left to settle after reset.
`define SFL_SETTLE 3'h4

`endif

// [sfl_ram.v]
`timescale 1ns/10ps
`include "sfl_defs.vh"

module sfl_ram (
  // Clock
  input wire mclk_in,
  // Write port
  input wire wr_en_in,
  input wire [`SFL_RAM_AW-1:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  // Read port
  input wire [`SFL_RAM_AW-1:0] rd_addr_in,
  output reg [7:0] rd_data_out
);

  reg [7:0] mem [0:(1<<`SFL_RAM_AW)-1];

  always @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule // sfl_ram

// [sfl_fifo.v]
`timescale 1ns/10ps

module sfl_fifo #(
  parameter W = 8,
  parameter D = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // Fill side
  input wire [W-1:0] in_data_in,
  input wire in_valid_in,
  output wire in_ready_out,
  // Drain side
  output wire [W-1:0] out_data_out,
  output wire out_valid_out,
  input wire out_ready_in
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire push;
  wire pop;

  assign in_ready_out = (cnt != D);
  assign out_valid_out = (cnt != {(AW+1){1'b0}});
  assign out_data_out = mem[rp];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always @(posedge mclk_in) begin
    if (push) begin
      mem[wp] <= in_data_in;
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= (wp == D - 1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == D - 1) ? {AW{1'b0}} : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

endmodule // sfl_fifo

// [sfl_loader.v]
`timescale 1ns/10ps
`include "sfl_defs.vh"

// Behaviour
// - After rate matching completes, send one zero byte first.
// - On 0x55 received, answer 0xAA.
// - Echo each of the two length bytes.
// - Host sends loader bytes; store each in RAM and echo it.
// - After all loader bytes, erase whole flash; on success send 0xAA.
// - If the whole erase fails, send 0xFF instead.
// - After erase success, hand control to the loaded RAM routine.
// - Boot mode: write command answered with XON 0x11.
// - After a chunk, send XON again unless it held the final record.
// - Boot mode: all data programmed, send ACK 0x06.
// - Boot mode: programming failure, send BEL 0x07.
// - User mode: write command gets XON; host sends count and address.
// - User mode: erase blocks from start address, then send ACK.
// - User mode: block erase failure sends BEL.
// - User mode: after erase ACK, host sends address and length, then XON; host sends chunk; program it.
// - User mode: keep remaining count; XON while nonzero after chunk.
// - User mode: ACK when all written, BEL on programming failure.
// - Blank-check each block and erase only those not blank.
module sfl_loader (
  // Clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // Mode strap and rate matching
  input wire user_mode_in,
  input wire baud_done_in,
  // Serial receive bytes
  input wire [7:0] rx_data_in,
  input wire rx_valid_in,
  output wire rx_ready_out,
  // Serial transmit bytes
  output reg [7:0] tx_data_out,
  output reg tx_valid_out,
  input wire tx_ready_in,
  // Flash engine
  output reg flash_req_out,
  output reg [1:0] flash_cmd_out,
  output reg [23:0] flash_addr_out,
  output reg [7:0] flash_wdata_out,
  input wire flash_ack_in,
  input wire flash_fail_in,
  input wire flash_blank_in,
  // Loader RAM
  output reg run_ram_out,
  input wire [`SFL_RAM_AW-1:0] ram_addr_in,
  output wire [7:0] ram_data_out
);

  localparam ST_IDLE = 12'h001;
  localparam ST_SYNC = 12'h002;
  localparam ST_LEN = 12'h004;
  localparam ST_LOAD = 12'h008;
  localparam ST_ERALL = 12'h010;
  localparam ST_CMD = 12'h020;
  localparam ST_HDR = 12'h040;
  localparam ST_BCHK = 12'h080;
  localparam ST_BERA = 12'h100;
  localparam ST_CHUNK = 12'h200;
  localparam ST_PROG = 12'h400;
  localparam ST_SEND = 12'h800;
  localparam RX_STATES = ST_SYNC | ST_LEN | ST_LOAD | ST_CMD | ST_HDR |
                         ST_CHUNK;

  //////////////////////////////////////////////////////////////////////////

  reg [11:0] state;
  reg [11:0] ret;
  reg mode_sync1;
  reg mode_sync2;
  reg mode_sync3;
  reg mode_user;
  reg [2:0] settle;
  reg [15:0] len;
  reg [15:0] len_cnt;
  reg [2:0] idx;
  reg [39:0] hdr;
  reg hdr_image;
  reg [7:0] blk_left;
  reg [23:0] blk_addr;
  reg [23:0] img_addr;
  reg [23:0] remain;
  reg [6:0] chunk_cnt;
  reg first_s;
  reg term;
  reg erase_busy;
  reg ram_we;
  reg [`SFL_RAM_AW-1:0] ram_waddr;
  reg [7:0] ram_wdata;

  wire [7:0] f_data;
  wire f_valid;
  wire f_ready;
  wire take;
  wire [47:0] next_hdr;
  wire [15:0] next_len;

  assign f_ready = |(state & RX_STATES);
  assign take = f_valid & f_ready;
  assign next_hdr = {hdr, f_data};
  assign next_len = {len[7:0], f_data};

  // True for the second byte of a termination record.
  function is_term_tail;
    input [7:0] b;
    begin
      is_term_tail = (b == `SFL_B_REC_9) || (b == `SFL_B_REC_8);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////

  // Receive bytes wait here so a slow flash step never drops host data.
  sfl_fifo #(
    .W(`SFL_FIFO_W),
    .D(`SFL_FIFO_D),
    .AW(`SFL_FIFO_AW)
  ) u_fifo (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .in_data_in(rx_data_in),
    .in_valid_in(rx_valid_in),
    .in_ready_out(rx_ready_out),
    .out_data_out(f_data),
    .out_valid_out(f_valid),
    .out_ready_in(f_ready)
  );

  sfl_ram u_ram (
    .mclk_in(mclk_in),
    .wr_en_in(ram_we),
    .wr_addr_in(ram_waddr),
    .wr_data_in(ram_wdata),
    .rd_addr_in(ram_addr_in),
    .rd_data_out(ram_data_out)
  );

  //////////////////////////////////////////////////////////////////////////

  task send;
    input [7:0] b;
    input [11:0] r;
    begin
      tx_data_out <= b;
      tx_valid_out <= 1'b1;
      ret <= r;
      state <= ST_SEND;
    end
  endtask

  task issue;
    input [1:0] c;
    input [23:0] a;
    input [7:0] d;
    begin
      flash_req_out <= 1'b1;
      flash_cmd_out <= c;
      flash_addr_out <= a;
      flash_wdata_out <= d;
    end
  endtask

  // Moves to the next block, or closes the erase phase with ACK.
  task next_block;
    begin
      if (blk_left == 8'h01) begin
        hdr_image <= 1'b1;
        idx <= 3'h0;
        send(`SFL_B_ACK, ST_HDR);
      end else begin
        blk_left <= blk_left - 8'h01;
        blk_addr <= blk_addr + `SFL_BLK_BYTES;
        issue(`SFL_FC_BLANK, blk_addr + `SFL_BLK_BYTES, 8'h00);
        state <= ST_BCHK;
      end
    end
  endtask

  // Strap passes three flops; the mode is taken while idling.
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      mode_sync1 <= 1'b0;
      mode_sync2 <= 1'b0;
      mode_sync3 <= 1'b0;
    end else begin
      mode_sync1 <= user_mode_in;
      mode_sync2 <= mode_sync1;
      mode_sync3 <= mode_sync2;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      ret <= ST_IDLE;
      mode_user <= 1'b0;
      settle <= 3'h0;
      len <= 16'h0000;
      len_cnt <= 16'h0000;
      idx <= 3'h0;
      hdr <= 40'h0000000000;
      hdr_image <= 1'b0;
      blk_left <= 8'h00;
      blk_addr <= 24'h000000;
      img_addr <= 24'h000000;
      remain <= 24'h000000;
      chunk_cnt <= 7'h00;
      first_s <= 1'b0;
      term <= 1'b0;
      erase_busy <= 1'b0;
      ram_we <= 1'b0;
      ram_waddr <= {`SFL_RAM_AW{1'b0}};
      ram_wdata <= 8'h00;
      tx_data_out <= 8'h00;
      tx_valid_out <= 1'b0;
      flash_req_out <= 1'b0;
      flash_cmd_out <= 2'h0;
      flash_addr_out <= 24'h000000;
      flash_wdata_out <= 8'h00;
      run_ram_out <= 1'b0;
    end else begin
      flash_req_out <= 1'b0;
      ram_we <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (mode_sync2 == mode_sync3) begin
            mode_user <= mode_sync3;
          end
          if (settle != `SFL_SETTLE) begin
            settle <= settle + 3'h1;
          end else if (mode_user) begin
            // The resident routine is already running in user mode.
            run_ram_out <= 1'b1;
            state <= ST_CMD;
          end else if (baud_done_in) begin
            send(`SFL_B_MATCH_END, ST_SYNC);
          end
        end
        ST_SYNC: begin
          if (take && f_data == `SFL_B_SYNC) begin
            idx <= 3'h0;
            len_cnt <= 16'h0000;
            send(`SFL_B_SYNC_ACK, ST_LEN);
          end
        end
        ST_LEN: begin
          if (take) begin
            len <= next_len;
            idx <= idx + 3'h1;
            if (idx == 3'h0) begin
              send(f_data, ST_LEN);
            end else if (next_len == 16'h0000) begin
              send(f_data, ST_ERALL);
            end else begin
              send(f_data, ST_LOAD);
            end
          end
        end
        ST_LOAD: begin
          if (take) begin
            ram_we <= 1'b1;
            ram_waddr <= len_cnt[`SFL_RAM_AW-1:0];
            ram_wdata <= f_data;
            len_cnt <= len_cnt + 16'h0001;
            if (len_cnt + 16'h0001 == len) begin
              send(f_data, ST_ERALL);
            end else begin
              send(f_data, ST_LOAD);
            end
          end
        end
        ST_ERALL: begin
          if (!erase_busy) begin
            erase_busy <= 1'b1;
            issue(`SFL_FC_ERASE_ALL, 24'h000000, 8'h00);
          end else if (flash_ack_in) begin
            erase_busy <= 1'b0;
            if (flash_fail_in) begin
              send(`SFL_B_ERASE_FAIL, ST_SYNC);
            end else begin
              run_ram_out <= 1'b1;
              send(`SFL_B_SYNC_ACK, ST_CMD);
            end
          end
        end
        ST_CMD: begin
          // Any byte other than the write command is dropped.
          if (take && f_data == `SFL_B_WCMD) begin
            idx <= 3'h0;
            hdr_image <= 1'b0;
            chunk_cnt <= 7'h00;
            first_s <= 1'b0;
            term <= 1'b0;
            if (mode_user) begin
              send(`SFL_B_XON, ST_HDR);
            end else begin
              img_addr <= 24'h000000;
              send(`SFL_B_XON, ST_CHUNK);
            end
          end
        end
        ST_HDR: begin
          if (take) begin
            hdr <= next_hdr[39:0];
            idx <= idx + 3'h1;
            if (!hdr_image && idx == `SFL_HDR_ERASE_LAST) begin
              blk_left <= next_hdr[31:24];
              blk_addr <= next_hdr[23:0];
              if (next_hdr[31:24] == 8'h00) begin
                hdr_image <= 1'b1;
                idx <= 3'h0;
                send(`SFL_B_ACK, ST_HDR);
              end else begin
                issue(`SFL_FC_BLANK, next_hdr[23:0], 8'h00);
                state <= ST_BCHK;
              end
            end else if (hdr_image && idx == `SFL_HDR_IMAGE_LAST) begin
              img_addr <= next_hdr[47:24];
              remain <= next_hdr[23:0];
              chunk_cnt <= 7'h00;
              if (next_hdr[23:0] == 24'h000000) begin
                send(`SFL_B_ACK, ST_CMD);
              end else begin
                send(`SFL_B_XON, ST_CHUNK);
              end
            end
          end
        end
        ST_BCHK: begin
          if (flash_ack_in) begin
            if (flash_blank_in) begin
              next_block;
            end else begin
              issue(`SFL_FC_ERASE_BLK, blk_addr, 8'h00);
              state <= ST_BERA;
            end
          end
        end
        ST_BERA: begin
          if (flash_ack_in) begin
            if (flash_fail_in) begin
              send(`SFL_B_BEL, ST_CMD);
            end else begin
              next_block;
            end
          end
        end
        ST_CHUNK: begin
          if (take) begin
            // Only the first two bytes of a chunk can mark the last record.
            if (chunk_cnt == 7'h00) begin
              first_s <= (f_data == `SFL_B_REC_S);
            end
            if (chunk_cnt == 7'h01 && first_s && is_term_tail(f_data)) begin
              term <= 1'b1;
            end
            issue(`SFL_FC_PROG, img_addr, f_data);
            state <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (flash_ack_in) begin
            if (flash_fail_in) begin
              if (mode_user) begin
                send(`SFL_B_BEL, ST_CMD);
              end else begin
                send(`SFL_B_BEL, ST_CMD);
              end
            end else begin
              img_addr <= img_addr + 24'h000001;
              chunk_cnt <= chunk_cnt + 7'h01;
              if (mode_user) begin
                remain <= remain - 24'h000001;
                if (remain == 24'h000001) begin
                  send(`SFL_B_ACK, ST_CMD);
                end else if (chunk_cnt == `SFL_CHUNK_LAST) begin
                  chunk_cnt <= 7'h00;
                  send(`SFL_B_XON, ST_CHUNK);
                end else begin
                  state <= ST_CHUNK;
                end
              end else if (chunk_cnt == `SFL_CHUNK_LAST) begin
                chunk_cnt <= 7'h00;
                first_s <= 1'b0;
                if (term || is_term_tail(8'h00)) begin
                  send(`SFL_B_ACK, ST_CMD);
                end else begin
                  send(`SFL_B_XON, ST_CHUNK);
                end
              end else begin
                state <= ST_CHUNK;
              end
            end
          end
        end
        ST_SEND: begin
          if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
            state <= ret;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sfl_loader

// [sfl_loader_asserts.sv]
`timescale 1ns/10ps
`include "sfl_defs.vh"

module sfl_loader_asserts (
  // Clock, reset and strap
  input wire mclk_in,
  input wire nrst_in,
  input wire user_mode_in,
  // Transmit bytes
  input wire [7:0] tx_data_out,
  input wire tx_valid_out,
  input wire tx_ready_in,
  // Flash engine
  input wire flash_req_out,
  input wire [1:0] flash_cmd_out,
  input wire flash_ack_in,
  input wire flash_fail_in,
  input wire flash_blank_in,
  // Loader RAM
  input wire run_ram_out
);
  reg pend;
  reg seen_tx;
  reg skip_blk;

  // A flash op counts as open from its request until its acknowledge.
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      pend <= 1'b0;
      seen_tx <= 1'b0;
      skip_blk <= 1'b0;
    end else begin
      pend <= flash_req_out | (pend & ~flash_ack_in);
      seen_tx <= seen_tx | tx_valid_out;
      if (flash_req_out)
        skip_blk <= 1'b0;
      else if (flash_ack_in && flash_blank_in &&
               flash_cmd_out == `SFL_FC_BLANK)
        skip_blk <= 1'b1;
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("tx byte moved");
  AST_TX_DROP: assert property (tx_valid_out && tx_ready_in |=>
    !tx_valid_out) else $error("tx valid held after accept");
  AST_RESET_QUIET: assert property ($rose(nrst_in) |-> !tx_valid_out &&
    !flash_req_out && !run_ram_out) else $error("busy out of reset");
  AST_ONE_OP: assert property (flash_req_out |-> !pend)
    else $error("second flash op while one open");
  AST_FIRST_ZERO: assert property (
    tx_valid_out && !seen_tx && !user_mode_in |->
    tx_data_out == `SFL_B_MATCH_END) else $error("first byte not zero");
  AST_ERASE_OK: assert property (
    flash_ack_in && !flash_fail_in && flash_cmd_out == `SFL_FC_ERASE_ALL
    |-> ##[1:8] tx_valid_out && tx_data_out == `SFL_B_SYNC_ACK)
    else $error("no success byte after erase");
  AST_ERASE_FAIL: assert property (
    flash_ack_in && flash_fail_in && flash_cmd_out == `SFL_FC_ERASE_ALL
    |-> ##[1:8] tx_valid_out && tx_data_out == `SFL_B_ERASE_FAIL)
    else $error("no failure byte after erase");
  AST_RUN_RAM: assert property (
    $rose(run_ram_out) && !user_mode_in |->
    flash_cmd_out == `SFL_FC_ERASE_ALL) else $error("run before erase");
  AST_BLK_FAIL: assert property (
    flash_ack_in && flash_fail_in && flash_cmd_out == `SFL_FC_ERASE_BLK
    |-> ##[1:8] tx_valid_out && tx_data_out == `SFL_B_BEL)
    else $error("no bell after block erase failure");
  AST_PROG_FAIL: assert property (
    flash_ack_in && flash_fail_in && flash_cmd_out == `SFL_FC_PROG
    |-> ##[1:8] tx_valid_out && tx_data_out == `SFL_B_BEL)
    else $error("no bell after program failure");
  AST_BLANK_SKIP: assert property (
    flash_req_out && flash_cmd_out == `SFL_FC_ERASE_BLK |-> !skip_blk)
    else $error("blank block erased");
  AST_DIRTY_ERASE: assert property (
    flash_ack_in && !flash_blank_in && flash_cmd_out == `SFL_FC_BLANK
    |-> ##[1:8] flash_req_out && flash_cmd_out == `SFL_FC_ERASE_BLK)
    else $error("dirty block not erased");

  cover property (flash_ack_in && flash_fail_in);
  cover property ($rose(run_ram_out));
  cover property (tx_valid_out && tx_data_out == `SFL_B_ACK);
endmodule // sfl_loader_asserts

bind sfl_loader sfl_loader_asserts sfl_loader_asserts_i (.mclk_in,
  .nrst_in, .user_mode_in, .tx_data_out, .tx_valid_out, .tx_ready_in,
  .flash_req_out, .flash_cmd_out, .flash_ack_in, .flash_fail_in,
  .flash_blank_in, .run_ram_out);

// [sfl_host.sv]
`timescale 1ns/10ps

module sfl_host (
  // Clock
  input wire mclk_in,
  // Bytes towards the loader
  output logic [7:0] byte_out,
  output logic byte_valid_out,
  input wire byte_ready_in,
  // Replies from the loader
  input wire [7:0] reply_in,
  input wire reply_valid_in,
  output logic reply_ready_out
);
  int stall = 0;

  initial begin
    byte_out = 8'h00;
    byte_valid_out = 1'b0;
    reply_ready_out = 1'b0;
  end

  // Ready is sampled at the falling edge, since inputs only move just
  // after a rising edge; this keeps the handshake free of races.
  task automatic put(input logic [7:0] b);
    logic r;
    int n;
    n = 0;
    @(posedge mclk_in);
    #1;
    byte_out = b;
    byte_valid_out = 1'b1;
    do begin
      @(negedge mclk_in);
      r = byte_ready_in;
      @(posedge mclk_in);
      n++;
    end while (r !== 1'b1 && n < 4000);
    #1;
    byte_valid_out = 1'b0;
    byte_out = ~b;
  endtask

  task automatic get(output logic [7:0] d);
    logic v;
    int n;
    n = 0;
    repeat (stall) @(posedge mclk_in);
    #1;
    reply_ready_out = 1'b1;
    do begin
      @(negedge mclk_in);
      v = reply_valid_in;
      d = reply_in;
      @(posedge mclk_in);
      n++;
    end while (v !== 1'b1 && n < 4000);
    // A reply that never comes reads as unknown, so it never matches.
    if (v !== 1'b1) begin
      d = 8'hXX;
    end
    #1;
    reply_ready_out = 1'b0;
  endtask
endmodule // sfl_host

// [tb_top.sv]
`timescale 1ns/10ps
`include "sfl_defs.vh"

module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic user_mode = 1'b0;
  logic baud_done = 1'b0;
  wire [7:0] rx_data;
  wire rx_valid;
  wire rx_ready;
  wire [7:0] tx_data;
  wire tx_valid;
  wire tx_ready;
  wire flash_req;
  wire [1:0] flash_cmd;
  wire [23:0] flash_addr;
  wire [7:0] flash_wdata;
  logic flash_ack = 1'b0;
  logic flash_fail = 1'b0;
  logic flash_blank = 1'b0;
  wire run_ram;
  logic [9:0] ram_addr = 10'h000;
  wire [7:0] ram_data;
  int checked = 0;
  int mismatches = 0;
  int lat = 1;
  int nprog = 0;
  int nerase = 0;
  logic [2:0] fail_cmd = 3'h4;
  logic [7:0] blank_bits = 8'h00;
  logic [23:0] last_addr = 24'h000000;
  logic [23:0] blk_addr = 24'h000000;
  logic [7:0] last_data = 8'h00;
  logic saw_full = 1'b0;
  logic [15:0] rows [0:5] = '{16'h55AA, 16'h0000, 16'h0303, 16'hA1A1,
    16'hB2B2, 16'hC3C3};

  always #12.5 mclk = ~mclk;

  sfl_loader sfl_loader_i (.mclk_in(mclk), .nrst_in(nrst),
    .user_mode_in(user_mode), .baud_done_in(baud_done),
    .rx_data_in(rx_data), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
    .tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .flash_req_out(flash_req), .flash_cmd_out(flash_cmd),
    .flash_addr_out(flash_addr), .flash_wdata_out(flash_wdata),
    .flash_ack_in(flash_ack), .flash_fail_in(flash_fail),
    .flash_blank_in(flash_blank), .run_ram_out(run_ram),
    .ram_addr_in(ram_addr), .ram_data_out(ram_data));

  sfl_host host_i (.mclk_in(mclk), .byte_out(rx_data),
    .byte_valid_out(rx_valid), .byte_ready_in(rx_ready),
    .reply_in(tx_data), .reply_valid_in(tx_valid),
    .reply_ready_out(tx_ready));

  ////////////////////////////////////////
  // Flash engine: one op at a time, failing only the command named.
  initial forever begin
    @(negedge mclk);
    if (flash_req === 1'b1) begin
      if (flash_cmd === `SFL_FC_PROG) begin
        nprog++;
        last_addr = flash_addr;
        last_data = flash_wdata;
      end
      if (flash_cmd === `SFL_FC_ERASE_BLK) begin
        nerase++;
        blk_addr = flash_addr;
      end
      repeat (lat) @(posedge mclk);
      #1;
      flash_ack = 1'b1;
      flash_fail = ({1'b0, flash_cmd} == fail_cmd);
      flash_blank = blank_bits[0];
      if (flash_cmd === `SFL_FC_BLANK)
        blank_bits = blank_bits >> 1;
      @(posedge mclk);
      #1;
      flash_ack = 1'b0;
      flash_fail = 1'b0;
    end
  end

  always @(negedge mclk) begin
    if (rx_valid && !rx_ready)
      saw_full = 1'b1;
  end

  ////////////////////////////////////////
  task automatic cmp_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_val(input string what, input logic [23:0] e,
                         input logic [23:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic recv(input logic [7:0] e);
    logic [7:0] d;
    host_i.get(d);
    cmp_byte("reply", e, d);
  endtask

  task automatic xfer(input logic [7:0] b, input logic [7:0] e);
    host_i.put(b);
    recv(e);
  endtask

  task automatic send_be(input logic [47:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      host_i.put(v[i*8 +: 8]);
    end
  endtask

  task automatic chunk(input logic [7:0] b0, input logic [7:0] b1,
                       input int n);
    for (int i = 0; i < n; i++) begin
      host_i.put(i == 0 ? b0 : i == 1 ? b1 : 8'(i) ^ 8'h3C);
    end
  endtask

  task automatic do_reset(input logic um);
    @(posedge mclk);
    #1;
    nrst = 1'b0;
    user_mode = um;
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
  endtask

  initial begin
    #(30000 * 25);
    mismatches++;
    summarize();
  end

  ////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    repeat (6) @(posedge mclk);
    #1;
    baud_done = 1'b1;
    recv(`SFL_B_MATCH_END);
    fail_cmd = {1'b0, `SFL_FC_ERASE_ALL};
    // The first pass fails its erase, so the host starts over.
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        xfer(rows[i][15:8], rows[i][7:0]);
      end
      recv(p == 0 ? `SFL_B_ERASE_FAIL : `SFL_B_SYNC_ACK);
      cmp_val("run_ram", 24'(p), {23'h000000, run_ram});
      fail_cmd = 3'h4;
    end
    for (int i = 0; i < 3; i++) begin
      ram_addr = i[9:0];
      repeat (2) @(posedge mclk);
      #1;
      cmp_byte("ram", rows[i + 3][7:0], ram_data);
    end
    host_i.put(8'h41);
    xfer(`SFL_B_WCMD, `SFL_B_XON);
    lat = 12;
    chunk(8'hA5, 8'h5A, 64);
    recv(`SFL_B_XON);
    cmp_val("fifo_full", 24'h000001, {23'h000000, saw_full});
    cmp_val("prog_addr", 24'h00003F, last_addr);
    lat = 1;
    host_i.stall = 3;
    chunk(`SFL_B_REC_S, `SFL_B_REC_9, 64);
    recv(`SFL_B_ACK);
    cmp_val("prog_count", 24'h000080, 24'(nprog));
    cmp_byte("prog_data", 8'h03, last_data);
    xfer(`SFL_B_WCMD, `SFL_B_XON);
    chunk(`SFL_B_REC_S, `SFL_B_REC_8, 64);
    recv(`SFL_B_ACK);
    xfer(`SFL_B_WCMD, `SFL_B_XON);
    fail_cmd = {1'b0, `SFL_FC_PROG};
    xfer(8'h12, `SFL_B_BEL);
    fail_cmd = 3'h4;

    do_reset(1'b1);
    blank_bits = 8'h01;
    xfer(`SFL_B_WCMD, `SFL_B_XON);
    send_be(48'h000002123000, 4);
    recv(`SFL_B_ACK);
    cmp_val("erase_count", 24'h000001, 24'(nerase));
    cmp_val("erase_addr", 24'h124000, blk_addr);
    cmp_val("run_ram", 24'h000001, {23'h000000, run_ram});
    send_be(48'h000040000046, 6);
    recv(`SFL_B_XON);
    chunk(8'h01, 8'h02, 64);
    recv(`SFL_B_XON);
    chunk(8'h01, 8'h02, 6);
    recv(`SFL_B_ACK);
    cmp_val("prog_addr", 24'h000085, last_addr);
    cmp_byte("prog_data", 8'h39, last_data);
    xfer(`SFL_B_WCMD, `SFL_B_XON);
    fail_cmd = {1'b0, `SFL_FC_ERASE_BLK};
    send_be(48'h000001000000, 4);
    recv(`SFL_B_BEL);
    fail_cmd = 3'h4;
    xfer(`SFL_B_WCMD, `SFL_B_XON);
    send_be(48'h000000000000, 4);
    recv(`SFL_B_ACK);
    send_be(48'h000000000001, 6);
    recv(`SFL_B_XON);
    fail_cmd = {1'b0, `SFL_FC_PROG};
    xfer(8'h77, `SFL_B_BEL);
    summarize();
  end
endmodule // tb_top
